// *** src/ftb_sram_port.sv ***
`timescale 1ns/10ps
`include "ftb_params.svh"

module ftb_sram_port #(
	parameter int ADDR_W     = `FTB_ADDR_W,     // word address bits
	parameter int LANES      = `FTB_LANES,      // byte lanes per word
	parameter int LANE_W     = `FTB_LANE_W,     // bits per lane
	parameter int FIFO_DEPTH = `FTB_FIFO_DEPTH  // write buffer entries
) (
	input  wire logic                     ref_clk,              // device clock, 40 MHz
	input  wire logic                     nrst,                 // async reset, low
	input  wire logic [ADDR_W-1:0]        addr,                 // word address
	input  wire logic                     processor_strobe_n,   // processor address strobe
	input  wire logic                     controller_strobe_n,  // controller address strobe
	input  wire logic                     burst_step_n,         // advance burst address
	input  wire logic                     byte_write_gate_n,    // qualifies lane selects
	input  wire logic [LANES-1:0]         lane_write_select_n,  // per-lane write selects
	input  wire logic                     all_bytes_write_n,    // write all lanes
	input  wire logic                     chip_select_a_n,      // select a, low
	input  wire logic                     chip_select_b,        // select b, high
	input  wire logic                     chip_select_c_n,      // select c, low
	input  wire logic                     out_enable_n,         // async output enable
	input  wire logic                     sleep_request,        // async sleep, high
	input  wire logic                     burst_order_sel,      // strap: 1 interleaved
	input  wire logic [LANES*LANE_W-1:0]  dq_in,                // data pins, input side
	output logic      [LANES*LANE_W-1:0]  dq_out,               // data pins, output side
	output logic                          dq_oe_n,              // data pins driven when low
	input  wire logic [LANES-1:0]         parity_lines_in,      // parity pins, input side
	output logic      [LANES-1:0]         parity_lines_out,     // parity pins, output side
	output logic                          parity_lines_oe_n,    // parity pins driven when low
	output logic                          write_ready           // write buffer has room
);

	localparam int BW      = `FTB_BURST_W;
	localparam int DATA_W  = LANES * LANE_W;
	localparam int WORD_W  = DATA_W + LANES;         // parity above data
	localparam int ENTRY_W = ADDR_W + LANES + WORD_W; // address, mask, word

	// pin synchronisers, first stage read only by the second
	logic oe_meta;          // output enable, first stage
	logic oe_sync;          // output enable, usable
	logic sleep_meta;       // sleep, first stage
	logic sleep_sync;       // sleep, usable
	logic order_meta;       // strap, first stage
	logic order_sync;       // strap, usable

	// access control
	ftb_pkg::ftb_state_type state_reg;  // current activity
	ftb_pkg::ftb_state_type state_next; // next activity
	logic [ADDR_W-1:0]  addr_reg;       // registered address
	logic [BW-1:0]      burst_low;      // counter output
	logic [ADDR_W-1:0]  cur_addr;       // address of the current beat
	logic               proc_load;      // processor strobe accepted
	logic               ctrl_load;      // controller strobe accepted
	logic               load;           // new external address
	logic               selected;       // all three selects active
	logic               active;         // a burst is in progress
	logic               step;           // burst advance this edge
	logic [LANES-1:0]   lane_mask;      // lanes written this edge
	logic               write_req;      // write inputs ask for a write
	logic               push;           // write enters the buffer
	logic [ADDR_W-1:0]  push_addr;      // target of that write

	// write buffer and array
	logic [WORD_W-1:0]  mem [2**ADDR_W]; // storage array
	logic [ENTRY_W-1:0] push_entry;      // entry offered to the buffer
	logic               drain_valid;     // buffered write waiting
	logic               drain_ready;     // array accepts a write
	logic [ENTRY_W-1:0] drain_entry;     // oldest buffered write
	logic [ADDR_W-1:0]  drain_addr;      // its address
	logic [LANES-1:0]   drain_mask;      // its lanes
	logic [WORD_W-1:0]  drain_word;      // its data and parity
	logic [WORD_W-1:0]  merged_word;     // array word with lanes replaced
	logic [WORD_W-1:0]  rd_word;         // word at the current beat
	logic               drive;           // pins driven

	// output enable and sleep are asynchronous, the strap is static
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			oe_meta    <= `FTB_OE_RESET;
			oe_sync    <= `FTB_OE_RESET;
			sleep_meta <= `FTB_SLEEP_RESET;
			sleep_sync <= `FTB_SLEEP_RESET;
			order_meta <= `FTB_ORDER_RESET;
			order_sync <= `FTB_ORDER_RESET;
		end else begin
			oe_meta    <= out_enable_n;
			oe_sync    <= oe_meta;
			sleep_meta <= sleep_request;
			sleep_sync <= sleep_meta;
			order_meta <= burst_order_sel;
			order_sync <= order_meta;
		end
	end

	// strobe decode: processor needs select a, controller yields to it
	assign proc_load = !processor_strobe_n && !chip_select_a_n;
	assign ctrl_load = !controller_strobe_n && processor_strobe_n;
	assign load      = (proc_load || ctrl_load) && !sleep_sync;
	assign selected  = !chip_select_a_n && chip_select_b && !chip_select_c_n;
	assign active    = state_reg != ftb_pkg::st_idle;
	assign step      = active && !load && !burst_step_n && !sleep_sync;

	// lane mask: all-bytes write overrides, lanes need the gate
	always_comb begin
		if (!all_bytes_write_n) begin
			lane_mask = '1;
		end else if (!byte_write_gate_n) begin
			lane_mask = ~lane_write_select_n;
		end else begin
			lane_mask = '0;
		end
	end
	assign write_req = |lane_mask;

	// controller loads write at once; processor loads defer writes a clock
	always_comb begin
		if (load) begin
			push = ctrl_load && selected && write_req;
		end else begin
			push = active && write_req && !sleep_sync;
		end
		push = push && write_ready;
	end
	assign push_addr  = load ? addr : cur_addr;
	assign push_entry = {push_addr, lane_mask, parity_lines_in, dq_in};

	// address register, loaded by any accepted strobe
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			addr_reg <= '0;
		end else if (load) begin
			addr_reg <= addr;
		end
	end

	// wraparound counter owns the two low address bits
	ftb_burst_counter u_burst (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.load       (load),
		.start      (addr[BW-1:0]),
		.step       (step),
		.interleave (order_sync),
		.low        (burst_low)
	);
	assign cur_addr = {addr_reg[ADDR_W-1:BW], burst_low};

	// activity: selects are judged only when an address is loaded
	always_comb begin
		state_next = state_reg;
		if (sleep_sync) begin
			state_next = ftb_pkg::st_idle;
		end else if (load) begin
			if (!selected) begin
				state_next = ftb_pkg::st_idle;
			end else if (push) begin
				state_next = ftb_pkg::st_write;
			end else if (!active) begin
				state_next = ftb_pkg::st_rd_first;
			end else begin
				state_next = ftb_pkg::st_read;
			end
		end else if (active) begin
			if (write_req) begin
				state_next = ftb_pkg::st_write;
			end else begin
				state_next = ftb_pkg::st_read;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ftb_pkg::st_idle;
		end else begin
			state_reg <= state_next;
		end
	end

	// write buffer; the array stops taking writes while asleep
	assign drain_ready = !sleep_sync;

	ftb_fifo #(
		.WIDTH (ENTRY_W),
		.DEPTH (FIFO_DEPTH)
	) u_wbuf (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (push),
		.in_ready  (write_ready),
		.in_data   (push_entry),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_data  (drain_entry)
	);
	assign drain_addr = drain_entry[ENTRY_W-1 -: ADDR_W];
	assign drain_mask = drain_entry[WORD_W +: LANES];
	assign drain_word = drain_entry[WORD_W-1:0];

	// per lane, data byte and its parity bit are replaced together
	generate
		for (genvar g = 0; g < LANES; g++) begin : g_lane
			assign merged_word[g*LANE_W +: LANE_W] = drain_mask[g] ?
				drain_word[g*LANE_W +: LANE_W] : mem[drain_addr][g*LANE_W +: LANE_W];
			assign merged_word[DATA_W+g] = drain_mask[g] ?
				drain_word[DATA_W+g] : mem[drain_addr][DATA_W+g];
		end
	endgenerate

	// array write, one buffered entry per clock
	always_ff @(posedge ref_clk) begin
		if (drain_valid && drain_ready) begin
			mem[drain_addr] <= merged_word;
		end
	end

	// flow-through read of the beat registered at the last edge
	assign rd_word          = mem[cur_addr];
	assign dq_out           = rd_word[DATA_W-1:0];
	assign parity_lines_out = rd_word[WORD_W-1:DATA_W];

	// drive only in read clocks, never first, write, idle or sleep,
	// and never while write controls present data on the pins
	assign drive             = (state_reg == ftb_pkg::st_read) && !oe_sync && !sleep_sync && !write_req;
	assign dq_oe_n           = !drive;
	assign parity_lines_oe_n = !drive;

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	a_pins_output: assert property (
		(state_reg == ftb_pkg::st_read) && !sleep_sync && !oe_sync && !write_req |-> !dq_oe_n && !parity_lines_oe_n)
		else $error("pins not driven in read with output enable low");

	a_first_read_mask: assert property (
		!active && load && selected && !push |=> dq_oe_n ##1 $past(state_reg) == ftb_pkg::st_rd_first)
		else $error("first read after deselect drove pins");

	a_burst_advance: assert property (
		step |=> burst_low != $past(burst_low) && addr_reg == $past(addr_reg))
		else $error("burst step did not advance address");

	a_addr_load: assert property (
		load |=> addr_reg == $past(addr) && burst_low == $past(addr[BW-1:0]))
		else $error("strobe did not load address");

	a_strobe_priority: assert property (
		!processor_strobe_n && !chip_select_a_n && !controller_strobe_n && !sleep_sync |-> !push)
		else $error("controller strobe acted beside processor strobe");

	a_proc_ignored: assert property (
		!active && chip_select_a_n && controller_strobe_n && !sleep_sync |=> !active)
		else $error("processor strobe taken with select a high");

	a_selects_held: assert property (
		active && !load && !sleep_sync |=> active)
		else $error("selects re-evaluated without address load");

	a_gate_write: assert property (
		push && all_bytes_write_n |-> !byte_write_gate_n && lane_mask == ~lane_write_select_n)
		else $error("lane write without byte write gate");

	a_global_write: assert property (
		push && !all_bytes_write_n |-> lane_mask == '1)
		else $error("all-bytes write missed a lane");

	a_sleep_quiet: assert property (
		sleep_sync |-> dq_oe_n && !push && !load ##1 !active)
		else $error("activity while asleep");

	a_write_release: assert property (
		state_reg == ftb_pkg::st_write || !active || write_req |-> dq_oe_n && parity_lines_oe_n)
		else $error("pins driven during write or deselect");

	a_order_linear: assert property (
		step && !order_sync && !load ##1 !$past(order_sync) |-> burst_low == $past(burst_low) + 2'h1)
		else $error("linear order did not add one");

	a_read_addr: assert property (
		load |=> cur_addr == $past(addr))
		else $error("read address not taken from last load");

	a_deselect_idle: assert property (
		load && !selected |=> !active && dq_oe_n && parity_lines_oe_n)
		else $error("deselect left the pins driven");

	a_oe_release: assert property (
		oe_sync |-> dq_oe_n && parity_lines_oe_n)
		else $error("pins driven with output enable high");

	a_ctrl_yield: assert property (
		!processor_strobe_n && chip_select_a_n && !controller_strobe_n |-> !load)
		else $error("controller strobe taken beside processor strobe");

	a_ctrl_write: assert property (
		ctrl_load && selected && write_req && write_ready && !sleep_sync |-> push)
		else $error("controller write not taken");

	a_lane_none: assert property (
		all_bytes_write_n && byte_write_gate_n |-> !write_req)
		else $error("write seen with gate and all-bytes write high");

	a_step_hold: assert property (
		active && !load && burst_step_n ##1 $stable(order_sync) |-> burst_low == $past(burst_low))
		else $error("burst address moved without burst step");

	a_linear_wrap: assert property (
		load && !order_sync ##1 (step && !order_sync) [*3] ##1 !order_sync
		|-> burst_low == BW'($past(addr[BW-1:0], 4) + 2'h3))
		else $error("linear burst did not wrap");

	a_interleave_wrap: assert property (
		load && order_sync ##1 (step && order_sync) [*3] ##1 order_sync
		|-> burst_low == ($past(addr[BW-1:0], 4) ^ 2'h3))
		else $error("interleaved burst did not end on start xor three");

	c_byte_write: cover property (
		push && all_bytes_write_n && !byte_write_gate_n);
	c_read_burst: cover property (
		load && selected && !push ##1 step [*3]);
	c_ctrl_write: cover property (
		ctrl_load && selected && push);
	c_proc_write: cover property (
		proc_load && selected ##1 push);
	c_sleep_entry: cover property (
		!sleep_sync ##1 sleep_sync);

endmodule

// *** shared/ftb_params.svh ***
`ifndef FTB_PARAMS_SVH
`define FTB_PARAMS_SVH

// array geometry: address width, byte lanes per word, bits per lane
`define FTB_ADDR_W      20
`define FTB_LANES       4
`define FTB_LANE_W      8

// width of the burst counter and of its start field
`define FTB_BURST_W     2

// depth of the write buffer in front of the array
`define FTB_FIFO_DEPTH  32

// reset values of the pin synchronisers
`define FTB_OE_RESET    1'b1
`define FTB_SLEEP_RESET 1'b0
`define FTB_ORDER_RESET 1'b1

`endif

// *** shared/ftb_pkg.sv ***
package ftb_pkg;

	// port activity, one-hot
	typedef enum logic [3:0] {
		st_idle     = 4'b0001, // deselected, pins released
		st_rd_first = 4'b0010, // first read clock after deselect
		st_read     = 4'b0100, // read clocks, output may drive
		st_write    = 4'b1000  // clock after a write was taken
	} ftb_state_type;

endpackage

// *** src/ftb_burst_counter.sv ***
`timescale 1ns/10ps
`include "ftb_params.svh"

// two-bit wraparound burst address generator
module ftb_burst_counter (
	input  wire logic                    ref_clk,    // device clock
	input  wire logic                    nrst,       // async reset, low
	input  wire logic                    load,       // take a new start address
	input  wire logic [`FTB_BURST_W-1:0] start,      // low address bits
	input  wire logic                    step,       // advance one beat
	input  wire logic                    interleave, // 1 interleaved, 0 linear
	output logic      [`FTB_BURST_W-1:0] low         // current low address bits
);

	logic [`FTB_BURST_W-1:0] start_reg; // first address of the burst
	logic [`FTB_BURST_W-1:0] count_reg; // beats taken since the load

	// start bits are captured on every load
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			start_reg <= '0;
		end else if (load) begin
			start_reg <= start;
		end
	end

	// beat count restarts on load and wraps after four beats
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
		end else if (load) begin
			count_reg <= '0;
		end else if (step) begin
			count_reg <= count_reg + 2'h1;
		end
	end

	// interleaved xors the count in, linear adds modulo four
	always_comb begin
		if (interleave) begin
			low = start_reg ^ count_reg;
		end else begin
			low = start_reg + count_reg;
		end
	end

endmodule

// *** src/ftb_fifo.sv ***
`timescale 1ns/10ps

// first-word-fall-through buffer with valid/ready on both sides
module ftb_fifo #(
	parameter int WIDTH = 8,  // entry width
	parameter int DEPTH = 32  // entries, a power of two
) (
	input  wire logic             ref_clk,   // device clock
	input  wire logic             nrst,      // async reset, low
	input  wire logic             in_valid,  // entry offered
	output logic                  in_ready,  // room for an entry
	input  wire logic [WIDTH-1:0] in_data,   // entry to store
	output logic                  out_valid, // entry available
	input  wire logic             out_ready, // drain takes the entry
	output logic      [WIDTH-1:0] out_data   // oldest entry
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH]; // entry storage
	logic [PW-1:0]    wr_ptr_reg;    // next slot to fill
	logic [PW-1:0]    rd_ptr_reg;    // oldest slot
	logic [PW:0]      count_reg;     // entries held
	logic             push;          // entry accepted
	logic             pop;           // entry drained

	// honest full and empty flags
	assign in_ready  = count_reg != (PW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data  = store[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage needs no reset
	always_ff @(posedge ref_clk) begin
		if (push) begin
			store[wr_ptr_reg] <= in_data;
		end
	end

	// pointers wrap naturally at a power-of-two depth
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

	// fill level
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
		end else if (push && !pop) begin
			count_reg <= count_reg + 1'b1;
		end else if (pop && !push) begin
			count_reg <= count_reg - 1'b1;
		end
	end

endmodule

// *** bench/ftb_host_model.sv ***
`timescale 1ns/10ps

// bus master side: drives strobes, write controls, selects and the shared data pins
module ftb_host_model #(
	parameter int ADDR_W = 6 // word address bits
) (
	input  wire logic              ref_clk,             // device clock
	input  wire logic [31:0]       dq_out,              // device data, output side
	input  wire logic              dq_oe_n,             // device drives data when low
	input  wire logic [3:0]        parity_lines_out,    // device parity, output side
	input  wire logic              parity_lines_oe_n,   // device drives parity when low
	output logic      [ADDR_W-1:0] addr,                // word address
	output logic                   processor_strobe_n,  // processor address strobe
	output logic                   controller_strobe_n, // controller address strobe
	output logic                   burst_step_n,        // burst advance
	output logic                   byte_write_gate_n,   // lane select qualifier
	output logic      [3:0]        lane_write_select_n, // per-lane write selects
	output logic                   all_bytes_write_n,   // write every lane
	output logic                   chip_select_a_n,     // select a, low
	output logic                   chip_select_b,       // select b, high
	output logic                   chip_select_c_n,     // select c, low
	output logic      [31:0]       dq_in,               // data pin level
	output logic      [3:0]        parity_lines_in      // parity pin level
);
	logic [35:0] host_d;   // value the host puts on the pins
	logic        host_drv; // host drives the pins
	logic [35:0] last_pin; // pin level one cycle ago
	logic [35:0] pin;      // resolved pin level

	// a released pin has no keeper: show the inverse of its last level, not a stale copy
	always_comb begin
		pin = host_drv ? host_d : ~last_pin;
		if (!dq_oe_n) pin[31:0] = dq_out;
		if (!parity_lines_oe_n) pin[35:32] = parity_lines_out;
	end

	assign dq_in = pin[31:0];
	assign parity_lines_in = pin[35:32];

	// remember the level for the next released cycle
	always @(posedge ref_clk) last_pin <= pin;

	// idle bus at time zero
	initial begin
		{processor_strobe_n, controller_strobe_n, burst_step_n, byte_write_gate_n} = 4'hf;
		lane_write_select_n = 4'hf;
		all_bytes_write_n = 1'h1;
		{chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h5;
		addr = '0;
		host_d = '0;
		host_drv = 1'h0;
		last_pin = '0;
	end

	// one bus cycle: values launch just after a rising edge and hold to the next one
	task automatic beat(input logic ps, input logic cs_s, input logic step, input logic gate,
		input logic [3:0] lanes, input logic gw, input logic [2:0] sel,
		input logic [ADDR_W-1:0] a, input logic [35:0] d, input logic drv);
		@(posedge ref_clk);
		processor_strobe_n <= ps;
		controller_strobe_n <= cs_s;
		burst_step_n <= step;
		byte_write_gate_n <= gate;
		lane_write_select_n <= lanes;
		all_bytes_write_n <= gw;
		{chip_select_a_n, chip_select_b, chip_select_c_n} <= sel;
		addr <= a;
		host_d <= d;
		host_drv <= drv;
	endtask
endmodule

// *** bench/flow_through_burst_sram_port_tb.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module flow_through_burst_sram_port_tb;
	localparam int AW = 6; // small address space for simulation

	logic          ref_clk = 1'h0;         // 40 MHz clock
	logic          nrst = 1'h0;            // async reset, low
	logic          out_enable_n = 1'h0;    // output enable
	logic          sleep_request = 1'h0;   // sleep input
	logic          burst_order_sel = 1'h0; // burst order strap
	logic [AW-1:0] addr;                   // word address
	logic          processor_strobe_n, controller_strobe_n, burst_step_n; // strobes and advance
	logic          byte_write_gate_n, all_bytes_write_n;                  // write controls
	logic [3:0]    lane_write_select_n, parity_lines_in, parity_lines_out; // lane-wide signals
	logic          chip_select_a_n, chip_select_b, chip_select_c_n;       // chip selects
	logic [31:0]   dq_in, dq_out;                                         // data pins
	logic          dq_oe_n, parity_lines_oe_n, write_ready;               // enables, buffer room
	logic [35:0]   exp_mem [64];                                          // expected array
	int            mismatches = 0;                                        // failed compares
	int            total_checks = 0;                                      // compares made

	always #12.5 ref_clk = ~ref_clk;

	ftb_sram_port #(.ADDR_W(AW)) dut (.ref_clk, .nrst, .addr, .processor_strobe_n, .controller_strobe_n,
		.burst_step_n, .byte_write_gate_n, .lane_write_select_n, .all_bytes_write_n, .chip_select_a_n,
		.chip_select_b, .chip_select_c_n, .out_enable_n, .sleep_request, .burst_order_sel, .dq_in,
		.dq_out, .dq_oe_n, .parity_lines_in, .parity_lines_out, .parity_lines_oe_n, .write_ready);

	ftb_host_model #(.ADDR_W(AW)) host (.ref_clk, .dq_out, .dq_oe_n, .parity_lines_out,
		.parity_lines_oe_n, .addr, .processor_strobe_n, .controller_strobe_n, .burst_step_n,
		.byte_write_gate_n, .lane_write_select_n, .all_bytes_write_n, .chip_select_a_n,
		.chip_select_b, .chip_select_c_n, .dq_in, .parity_lines_in);

	// low two address bits of beat k: add for linear, xor for interleaved
	function automatic logic [1:0] beat_low(input logic [1:0] s, input logic [1:0] k, input logic il);
		return il ? (s ^ k) : (s + k);
	endfunction

	// quiet cycle, device deselected, pins released
	task automatic idle();
		host.beat(1'h1, 1'h1, 1'h1, 1'h1, 4'hf, 1'h1, 3'h5, '0, '0, 1'h0);
	endtask

	// deselect, load from idle, then a four-beat burst with the selects dropped
	task automatic read_check(input logic [AW-1:0] base, input logic [1:0] start, input logic drive);
		logic [AW-1:0] a;
		host.beat(1'h0, 1'h1, 1'h1, 1'h1, 4'hf, 1'h1, 3'h0, '0, '0, 1'h0);
		host.beat(1'h0, 1'h1, 1'h1, 1'h1, 4'hf, 1'h1, 3'h2, base | AW'(start), '0, 1'h0);
		@(negedge ref_clk);
		`CHK(dq_oe_n, 1'h1)
		host.beat(1'h1, 1'h1, 1'h0, 1'h1, 4'hf, 1'h1, 3'h5, '0, '0, 1'h0);
		@(negedge ref_clk);
		a = base | AW'(start);
		`CHK(dq_oe_n, 1'h1)
		`CHK({parity_lines_out, dq_out}, exp_mem[a])
		for (int k = 1; k < 4; k++) begin
			host.beat(1'h1, 1'h1, k == 3, 1'h1, 4'hf, 1'h1, 3'h5, '0, '0, 1'h0);
			@(negedge ref_clk);
			a = base | AW'(beat_low(start, 2'(k), burst_order_sel));
			`CHK({parity_lines_out, dq_out}, exp_mem[a])
			`CHK(dq_oe_n, !drive)
			`CHK(parity_lines_oe_n, !drive)
		end
	endtask

	// four back-to-back controller writes of all lanes, selects active and gate left inactive
	task automatic t_write_words(input logic [AW-1:0] base);
		logic [35:0] d;
		for (int k = 0; k < 4; k++) begin
			d = 36'h9_3c5a_0f10 + 36'h1_0101_0101 * 36'(k);
			exp_mem[base + AW'(k)] = d;
			host.beat(1'h1, 1'h0, 1'h1, 1'h1, 4'hf, 1'h0, 3'h2, base + AW'(k), d, 1'h1);
		end
		idle();
		@(negedge ref_clk);
		`CHK(dq_oe_n, 1'h1)
		`CHK(write_ready, 1'h1)
		read_check(base, 2'h1, 1'h1);
		$display("write words done");
	endtask

	// both strap levels, start points that tell the orders apart
	task automatic t_orders();
		for (int il = 0; il < 2; il++) begin
			@(posedge ref_clk);
			burst_order_sel <= il[0];
			repeat (3) idle();
			read_check(6'h08, 2'h1, 1'h1);
			read_check(6'h14, 2'h3, 1'h1);
		end
		$display("burst orders done");
	endtask

	// output enable high keeps the pins released through a whole burst
	task automatic t_oe_off();
		@(posedge ref_clk);
		out_enable_n <= 1'h1;
		repeat (3) idle();
		read_check(6'h14, 2'h0, 1'h0);
		@(posedge ref_clk);
		out_enable_n <= 1'h0;
		repeat (3) idle();
		$display("output enable done");
	endtask

	// gated write of lanes 0 and 2, then lane selects without the gate
	task automatic t_byte_write();
		logic [35:0] d;
		d = 36'h6_7788_99aa;
		host.beat(1'h0, 1'h1, 1'h1, 1'h1, 4'hf, 1'h1, 3'h2, 6'h0a, '0, 1'h0);
		host.beat(1'h1, 1'h1, 1'h1, 1'h0, 4'ha, 1'h1, 3'h5, '0, d, 1'h1);
		@(negedge ref_clk);
		`CHK(dq_oe_n, 1'h1)
		`CHK(parity_lines_oe_n, 1'h1)
		host.beat(1'h1, 1'h1, 1'h1, 1'h1, 4'h0, 1'h1, 3'h5, '0, ~d, 1'h1);
		@(negedge ref_clk);
		`CHK(dq_oe_n, 1'h1)
		idle();
		exp_mem[6'h0a] = (exp_mem[6'h0a] & ~36'h5_00ff_00ff) | (d & 36'h5_00ff_00ff);
		read_check(6'h08, 2'h2, 1'h1);
		$display("byte write done");
	endtask

	// ignored strobes: select a high, then both strobes low with a write pending
	task automatic t_strobes();
		host.beat(1'h0, 1'h1, 1'h1, 1'h1, 4'hf, 1'h1, 3'h0, '0, '0, 1'h0);
		host.beat(1'h0, 1'h0, 1'h1, 1'h1, 4'hf, 1'h0, 3'h6, 6'h14, 36'h0_dead_beef, 1'h1);
		host.beat(1'h0, 1'h0, 1'h1, 1'h1, 4'hf, 1'h0, 3'h2, 6'h14, 36'h0_dead_beef, 1'h1);
		idle();
		read_check(6'h14, 2'h0, 1'h1);
		$display("strobes done");
	endtask

	// a write attempted while asleep leaves the array untouched
	task automatic t_sleep();
		@(posedge ref_clk);
		sleep_request <= 1'h1;
		repeat (3) idle();
		host.beat(1'h1, 1'h0, 1'h1, 1'h1, 4'hf, 1'h0, 3'h2, 6'h15, 36'h0_1234_5678, 1'h1);
		idle();
		@(posedge ref_clk);
		sleep_request <= 1'h0;
		repeat (3) idle();
		read_check(6'h14, 2'h1, 1'h1);
		$display("sleep done");
	endtask

	// counts, verdict, end of run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge ref_clk);
		t_write_words(6'h08);
		t_write_words(6'h14);
		t_orders();
		t_oe_off();
		t_byte_write();
		t_strobes();
		t_sleep();
		tally_and_finish();
	end

	// watchdog well beyond the roughly 110 cycles the tests need
	initial begin
		#(3000 * 25);
		mismatches++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule
